//--- common/crm_pkg.sv
// What this block does
// - Three sizes exist, 32x18, 128x36 and 4Kx144, each reshaped by width.
// - True dual-port, on medium and large only, does any two accesses at once.
// - Simple dual-port reads and writes together; a clash gives old or filler.
// - Single-port never reads while writing; the written word shows through on a bypassed output only.
// - The two ports may use different widths over the same storage bits.
// - Address, data and controls are all captured in input registers.
// - The array write is strobed internally from the captured write enable.
// - Each port's output register can be bypassed by configuration.
// - Small and medium simple dual-port reads may capture on the falling edge.
// - Medium may hold two independent single-port memories in its halves.
// - Clear hits input and output registers; on large the outputs only.
// - Input clear shows at once on a bypassed output only, output clear at once.
// - Every byte has a parity bit; medium and large have byte enables.
package crm_pkg;
    typedef enum logic [1:0] {CRM_SP, CRM_SDP, CRM_TDP, CRM_SPLIT}
        crm_mode_type;
    localparam int CRM_SMALL = 0;
    localparam int CRM_MEDIUM = 1;
    localparam int CRM_LARGE = 2;
    // Native width, depth, widest shift and port address bits per size
    localparam int CRM_NW [3] = '{18, 36, 144};
    localparam int CRM_DEPTH [3] = '{32, 128, 4096};
    localparam int CRM_MAXSH [3] = '{4, 5, 7};
    localparam int CRM_AW [3] = '{9, 12, 19};
    // Register map
    localparam logic [7:0] CRM_CFG_OFS = 8'h00;
    localparam logic [7:0] CRM_STAT_OFS = 8'h04;
    localparam int CRM_CFG_MODE = 0;
    localparam int CRM_CFG_OREG_A = 2;
    localparam int CRM_CFG_OREG_B = 3;
    localparam int CRM_CFG_OLD = 4;
    localparam int CRM_CFG_FLOW = 5;
    localparam int CRM_CFG_PAR = 6;
    localparam int CRM_CFG_SH_A = 8;
    localparam int CRM_CFG_SH_B = 12;
    localparam logic [31:0] CRM_CFG_RST = 32'h0000_0050;
    localparam int CRM_ST_CLASH = 0;
    localparam int CRM_ST_WR_A = 1;
    localparam int CRM_ST_WR_B = 2;
    localparam int CRM_ST_SIZE = 8;
    // Filler bit for undefined read data
    localparam logic CRM_UNDEF_BIT = 1'b1;
endpackage

//--- design/crm_ram.sv
`timescale 1ns/1ps
`default_nettype none
module crm_ram #(
    parameter int VARIANT = crm_pkg::CRM_MEDIUM
) (
    // Clock and resets
    input wire logic CLK_SYS,
    input wire logic ARST_N,
    input wire logic IN_CLR,
    input wire logic OUT_CLR,
    // Port A
    input wire logic [crm_pkg::CRM_AW[VARIANT]-1:0] A_ADDR,
    input wire logic [crm_pkg::CRM_NW[VARIANT]-1:0] A_DATA,
    input wire logic [crm_pkg::CRM_NW[VARIANT]/9-1:0] A_BE,
    input wire logic A_WE,
    input wire logic A_RE,
    output logic [crm_pkg::CRM_NW[VARIANT]-1:0] A_Q,
    // Port B
    input wire logic [crm_pkg::CRM_AW[VARIANT]-1:0] B_ADDR,
    input wire logic [crm_pkg::CRM_NW[VARIANT]-1:0] B_DATA,
    input wire logic [crm_pkg::CRM_NW[VARIANT]/9-1:0] B_BE,
    input wire logic B_WE,
    input wire logic B_RE,
    output logic [crm_pkg::CRM_NW[VARIANT]-1:0] B_Q,
    // APB slave
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [7:0] PADDR,
    input wire logic [31:0] PWDATA,
    output logic [31:0] PRDATA,
    output logic PREADY,
    output logic PSLVERR
);
    import crm_pkg::*;
    localparam int NW = CRM_NW[VARIANT];
    localparam int NB = NW / 9;
    localparam int AW = CRM_AW[VARIANT];
    localparam int DEP = CRM_DEPTH[VARIANT];
    localparam int DW = $clog2(DEP);
    localparam int MSH = CRM_MAXSH[VARIANT];
    localparam logic [NW-1:0] UNDEF = {NW{CRM_UNDEF_BIT}};
    localparam logic [NW-1:0] OUT_RST = (VARIANT == CRM_LARGE) ? UNDEF : '0;

    // ==========================================================
    // Slice helpers for mixed widths and parity-free words
    function automatic logic [NW-1:0] rd_slice(input logic [NW-1:0] w,
        input int sh, input int ln, input logic par);
        int pw;
        int l;
        rd_slice = '0;
        pw = (par ? NW : NB * 8) >> sh;
        for (int i = 0; i < NW; i++) begin
            l = ln * pw + i;
            if (!par) l = l + l / 8;
            if (i < pw && l < NW) rd_slice[i] = w[l];
        end
    endfunction

    function automatic logic [NW-1:0] wr_merge(input logic [NW-1:0] w,
        input logic [NW-1:0] d, input logic [NB-1:0] be, input int sh,
        input int ln, input logic par);
        int pw;
        int l;
        int b;
        wr_merge = w;
        pw = (par ? NW : NB * 8) >> sh;
        for (int i = 0; i < NW; i++) begin
            l = ln * pw + i;
            if (!par) l = l + l / 8;
            b = par ? i / 9 : i / 8;
            if (i < pw && l < NW && b < NB &&
                (VARIANT == CRM_SMALL || be[b]))
                wr_merge[l] = d[i];
        end
    endfunction

    // ==========================================================
    // Configuration and status registers
    logic [31:0] cfg_q;
    logic clash_q;
    logic [31:0] prdata_q;
    logic pready_q;
    logic pslverr_q;
    wire sel_cfg = PADDR == CRM_CFG_OFS;
    wire sel_stat = PADDR == CRM_STAT_OFS;
    wire setup = PSEL & ~PENABLE;
    wire acc = PSEL & PENABLE & pready_q;
    wire wr_cfg = acc & PWRITE & sel_cfg;
    wire clr_clash = acc & PWRITE & sel_stat & PWDATA[CRM_ST_CLASH];

    crm_mode_type mode_raw;
    crm_mode_type mode;
    assign mode_raw = crm_mode_type'(cfg_q[CRM_CFG_MODE +: 2]);
    always_comb begin
        mode = mode_raw;
        if (mode_raw == CRM_TDP && VARIANT == CRM_SMALL) mode = CRM_SDP;
        if (mode_raw == CRM_SPLIT && VARIANT != CRM_MEDIUM) mode = CRM_SP;
    end
    wire par = cfg_q[CRM_CFG_PAR];
    wire flow = cfg_q[CRM_CFG_FLOW] && mode == CRM_SDP &&
        VARIANT != CRM_LARGE;
    wire old_ok = cfg_q[CRM_CFG_OLD] && VARIANT != CRM_LARGE;
    wire oreg [2];
    assign oreg[0] = cfg_q[CRM_CFG_OREG_A];
    assign oreg[1] = cfg_q[CRM_CFG_OREG_B] & ~flow;
    wire one_port = mode == CRM_SP || mode == CRM_SPLIT;

    // ==========================================================
    // Input registers
    wire in_rst_n = ARST_N & ~(IN_CLR & (VARIANT != CRM_LARGE));
    wire out_rst_n = ARST_N & ~OUT_CLR;
    logic [AW-1:0] addr_q [2];
    logic [NW-1:0] data_q [2];
    logic [NB-1:0] be_q [2];
    logic we_q [2];
    logic re_q [2];
    logic [AW-1:0] addr_n_q;
    logic re_n_q;
    wire [AW-1:0] addr_in [2];
    wire [NW-1:0] data_in [2];
    wire [NB-1:0] be_in [2];
    wire we_in [2];
    wire re_in [2];
    assign addr_in[0] = A_ADDR;
    assign addr_in[1] = B_ADDR;
    assign data_in[0] = A_DATA;
    assign data_in[1] = B_DATA;
    assign be_in[0] = A_BE;
    assign be_in[1] = B_BE;
    assign we_in[0] = A_WE;
    assign we_in[1] = B_WE;
    assign re_in[0] = A_RE;
    assign re_in[1] = B_RE;

    // Falling-edge read capture for flow-through
    always_ff @(negedge CLK_SYS or negedge in_rst_n) begin
        if (!in_rst_n) begin
            addr_n_q <= '0;
            re_n_q <= 1'b0;
        end else begin
            addr_n_q <= B_ADDR;
            re_n_q <= B_RE;
        end
    end

    // ==========================================================
    // Storage, write strobe and read path
    logic [NW-1:0] mem [DEP];
    logic [NW-1:0] out_q [2];
    logic [NW-1:0] rword [2];
    logic [NW-1:0] rdata [2];
    logic [NW-1:0] wword [2];
    logic [DW-1:0] widx [2];
    logic [DW-1:0] ridx [2];
    logic [2:0] sh [2];
    wire we_ok [2];
    wire re_ok [2];
    wire we_eff [2];
    wire re_eff [2];
    wire clash [2];
    assign sh[0] = cfg_q[CRM_CFG_SH_A +: 3];
    assign sh[1] = cfg_q[CRM_CFG_SH_B +: 3];
    assign we_ok[0] = 1'b1;
    assign re_ok[0] = mode != CRM_SDP;
    assign we_ok[1] = mode == CRM_TDP || mode == CRM_SPLIT;
    assign re_ok[1] = mode != CRM_SP;

    for (genvar p = 0; p < 2; p++) begin : g_port
        wire [AW-1:0] raddr = (p == 1 && flow) ? addr_n_q : addr_q[p];
        wire re_src = (p == 1 && flow) ? re_n_q : re_q[p];
        wire [AW-1:0] wsh = addr_q[p] >> sh[p];
        wire [AW-1:0] rsh = raddr >> sh[p];
        wire [AW-1:0] wln = addr_q[p] & ~({AW{1'b1}} << sh[p]);
        wire [AW-1:0] rln = raddr & ~({AW{1'b1}} << sh[p]);
        always_comb begin
            widx[p] = wsh[DW-1:0];
            ridx[p] = rsh[DW-1:0];
            if (mode == CRM_SPLIT) begin
                widx[p][DW-1] = p[0];
                ridx[p][DW-1] = p[0];
            end
        end
        assign we_eff[p] = we_q[p] & we_ok[p];
        assign re_eff[p] = re_src & re_ok[p] & ~(one_port & we_eff[p]);
        assign clash[p] = re_eff[p] & we_eff[1-p] & widx[1-p] == ridx[p];

        always_ff @(posedge CLK_SYS or negedge in_rst_n) begin
            if (!in_rst_n) begin
                addr_q[p] <= '0;
                data_q[p] <= '0;
                be_q[p] <= '0;
                we_q[p] <= 1'b0;
                re_q[p] <= 1'b0;
            end else begin
                addr_q[p] <= addr_in[p];
                data_q[p] <= data_in[p];
                be_q[p] <= be_in[p];
                we_q[p] <= we_in[p];
                re_q[p] <= re_in[p];
            end
        end

        // Own write shows through; a clash gives old data or filler
        always_comb begin
            if (we_eff[p] && widx[p] == ridx[p])
                rword[p] = wword[p];
            else if (clash[p])
                rword[p] = old_ok ? mem[ridx[p]] : UNDEF;
            else
                rword[p] = mem[ridx[p]];
            rdata[p] = rd_slice(rword[p], int'(sh[p]), int'(rln), par);
        end

        always_ff @(posedge CLK_SYS or negedge out_rst_n) begin
            if (!out_rst_n)
                out_q[p] <= OUT_RST;
            else if (re_eff[p])
                out_q[p] <= rdata[p];
        end
    end

    // Port B merges on top of port A when both hit one word
    always_comb begin
        wword[0] = wr_merge(mem[widx[0]], data_q[0], be_q[0],
            int'(sh[0]), int'(g_port[0].wln), par);
        wword[1] = wr_merge((we_eff[0] && widx[0] == widx[1]) ? wword[0] :
            mem[widx[1]], data_q[1], be_q[1], int'(sh[1]),
            int'(g_port[1].wln), par);
    end

    // Internal strobe from captured enables, no user pulse timing
    always_ff @(posedge CLK_SYS) begin
        if (we_eff[0]) mem[widx[0]] <= wword[0];
        if (we_eff[1]) mem[widx[1]] <= wword[1];
    end

    assign A_Q = oreg[0] ? out_q[0] : rdata[0];
    assign B_Q = oreg[1] ? out_q[1] : rdata[1];

    // ==========================================================
    // APB register process
    wire [31:0] stat_v = (32'(VARIANT) << CRM_ST_SIZE) |
        (32'(we_q[1]) << CRM_ST_WR_B) | (32'(we_q[0]) << CRM_ST_WR_A) |
        (32'(clash_q) << CRM_ST_CLASH);
    wire [31:0] rd_v = sel_cfg ? cfg_q : (sel_stat ? stat_v : 32'h0);
    always_ff @(posedge CLK_SYS or negedge ARST_N) begin
        if (!ARST_N) begin
            cfg_q <= CRM_CFG_RST;
            clash_q <= 1'b0;
            prdata_q <= 32'h0;
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
        end else begin
            if (wr_cfg) cfg_q <= PWDATA;
            clash_q <= clash[0] | clash[1] | (clash_q & ~clr_clash);
            pready_q <= setup;
            if (setup) prdata_q <= PWRITE ? 32'h0 : rd_v;
            if (setup) pslverr_q <= ~(sel_cfg | sel_stat);
        end
    end
    assign PRDATA = prdata_q;
    assign PREADY = pready_q;
    assign PSLVERR = pslverr_q;

    // ==========================================================
    // Checks
    a_small_no_tdp: assert property (@(posedge CLK_SYS) disable iff (!ARST_N)
        VARIANT == CRM_SMALL |-> !we_ok[1])
        else $error("small size allowed a second write port");
    a_rdw_old: assert property (@(posedge CLK_SYS) disable iff (!ARST_N)
        clash[1] && old_ok |-> rword[1] == mem[ridx[1]])
        else $error("clash read did not return old data");
    a_sp_single: assert property (@(posedge CLK_SYS) disable iff (!ARST_N)
        mode == CRM_SP |-> !re_eff[1] && !we_eff[1] &&
        !(re_eff[0] && we_eff[0]))
        else $error("single-port mode overlapped accesses");
    a_regout_lag: assert property (@(posedge CLK_SYS) disable iff (!out_rst_n)
        oreg[0] && re_eff[0] ##1 oreg[0] |-> A_Q == $past(rdata[0]))
        else $error("registered output missed the read word");
    a_in_capture: assert property (
        @(posedge CLK_SYS) disable iff (!in_rst_n)
        $past(in_rst_n) |-> addr_q[1] == $past(B_ADDR) &&
        we_q[0] == $past(A_WE))
        else $error("input registers did not capture the inputs");
    a_flow_bypass: assert property (@(posedge CLK_SYS) disable iff (!ARST_N)
        flow |-> !oreg[1] && mode == CRM_SDP && VARIANT != CRM_LARGE)
        else $error("flow-through read kept an output register");
    a_split_half: assert property (@(posedge CLK_SYS) disable iff (!ARST_N)
        mode == CRM_SPLIT |-> widx[0][DW-1] == 1'b0 &&
        widx[1][DW-1] == 1'b1)
        else $error("split halves overlapped");
    a_out_clear: assert property (@(posedge CLK_SYS) disable iff (!ARST_N)
        OUT_CLR |-> out_q[0] == OUT_RST && out_q[1] == OUT_RST)
        else $error("output clear not seen at once");
    a_large_iclr: assert property (@(posedge CLK_SYS) disable iff (!ARST_N)
        VARIANT == CRM_LARGE && IN_CLR ##1 IN_CLR |->
        we_q[0] == $past(A_WE))
        else $error("input clear touched large input registers");
    a_be_mask: assert property (@(posedge CLK_SYS) disable iff (!ARST_N)
        VARIANT != CRM_SMALL && we_eff[0] && be_q[0] == '0 |->
        wword[0] == mem[widx[0]])
        else $error("masked bytes were written");
    a_large_undef: assert property (@(posedge CLK_SYS) disable iff (!ARST_N)
        VARIANT == CRM_LARGE && clash[0] |-> rword[0] == UNDEF)
        else $error("large clash read not filler");
    c_tdp_both: cover property (@(posedge CLK_SYS) disable iff (!ARST_N)
        mode == CRM_TDP && we_eff[0] && we_eff[1]);
    c_sdp_clash: cover property (@(posedge CLK_SYS) disable iff (!ARST_N)
        mode == CRM_SDP && clash[1]);
    c_flow_read: cover property (@(posedge CLK_SYS) disable iff (!ARST_N)
        flow && re_eff[1]);
endmodule // crm_ram
`default_nettype wire

//--- dv/crm_user_model.sv
`timescale 1ns/1ps
`default_nettype none
// ==========================================
// Fabric logic driving both memory ports
module crm_user_model (
    // Clock
    input wire logic clk,
    // Port A
    output logic [11:0] a_addr,
    output logic [35:0] a_data,
    output logic [3:0] a_be,
    output logic a_we,
    output logic a_re,
    // Port B
    output logic [11:0] b_addr,
    output logic [35:0] b_data,
    output logic [3:0] b_be,
    output logic b_we,
    output logic b_re
);
    initial begin
        {a_addr, a_data, a_be, a_we, a_re} = '0;
        {b_addr, b_data, b_be, b_we, b_re} = '0;
    end
    task automatic set_a(input logic we, re, input logic [11:0] ad,
                         input logic [35:0] d, input logic [3:0] be);
        {a_we, a_re, a_addr, a_data, a_be} <= {we, re, ad, d, be};
    endtask
    task automatic set_b(input logic we, re, input logic [11:0] ad,
                         input logic [35:0] d, input logic [3:0] be);
        {b_we, b_re, b_addr, b_data, b_be} <= {we, re, ad, d, be};
    endtask
    // Released lines show no stale value
    task automatic idle();
        {a_we, a_re, b_we, b_re} <= 4'h0;
        {a_addr, a_data} <= ~{a_addr, a_data};
        {b_addr, b_data} <= ~{b_addr, b_data};
    endtask
endmodule // crm_user_model
`default_nettype wire

//--- dv/testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench;
    import crm_pkg::*;
    logic clk_sys = 1'b0;
    logic arst_n = 1'b0;
    logic in_clr = 1'b0;
    logic out_clr = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [31:0] prdata, rd;
    logic pready, pslverr, sl;
    logic [11:0] a_addr, b_addr;
    logic [35:0] a_data, b_data, a_q, b_q, v;
    logic [35:0] mem [128];
    logic [3:0] a_be, b_be;
    logic a_we, a_re, b_we, b_re;
    int failures = 0;
    int comparisons = 0;
    int seed = 98;
    int ad;
    // ==========================================
    // Clock, design and fabric model
    initial begin
        forever #20 clk_sys = ~clk_sys;
    end
    crm_ram #(.VARIANT(CRM_MEDIUM)) uut (.CLK_SYS(clk_sys), .ARST_N(arst_n),
        .IN_CLR(in_clr), .OUT_CLR(out_clr), .A_ADDR(a_addr), .A_DATA(a_data),
        .A_BE(a_be), .A_WE(a_we), .A_RE(a_re), .A_Q(a_q), .B_ADDR(b_addr),
        .B_DATA(b_data), .B_BE(b_be), .B_WE(b_we), .B_RE(b_re), .B_Q(b_q),
        .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr),
        .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr));
    crm_user_model um (.clk(clk_sys), .a_addr(a_addr), .a_data(a_data),
        .a_be(a_be), .a_we(a_we), .a_re(a_re), .b_addr(b_addr),
        .b_data(b_data), .b_be(b_be), .b_we(b_we), .b_re(b_re));
    // ==========================================
    // Checking and bus tasks
    task automatic results();
        if (failures == 0 && comparisons > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    task automatic chk(input string nm, input logic [35:0] e, g);
        comparisons++;
        if (g !== e) begin
            failures++;
            $display("Error %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic apb(input logic wr, input logic [7:0] a,
                       input logic [31:0] wd);
        int n;
        n = 0;
        {psel, pwrite, paddr, pwdata} <= {1'b1, wr, a, wd};
        @(posedge clk_sys);
        penable <= 1'b1;
        do begin
            @(posedge clk_sys);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (pready !== 1'b1) begin
            failures++;
            results();
        end
        rd = prdata;
        sl = pslverr;
        {psel, penable} <= 2'b00;
        // Idle edge so a following call never drives psel twice at once
        @(posedge clk_sys);
    endtask
    function automatic logic [31:0] cfg(input int m, oa, old, shb);
        return 32'(64 | m | oa << CRM_CFG_OREG_A | old << CRM_CFG_OLD
                   | shb << CRM_CFG_SH_B);
    endfunction
    function automatic logic [35:0] merge(input logic [35:0] o, n,
                                          input logic [3:0] be);
        for (int b = 0; b < 4; b++) begin
            if (be[b]) o[9*b+:9] = n[9*b+:9];
        end
        return o;
    endfunction
    task automatic wr_a(input int a, input logic [35:0] d,
                        input logic [3:0] be);
        um.set_a(1'b1, 1'b0, 12'(a), d, be);
        @(posedge clk_sys);
        mem[a] = merge(mem[a], d, be);
    endtask
    // Bypassed output is valid just after the capture edge
    task automatic rd_a(input int a);
        um.set_a(1'b0, 1'b1, 12'(a), 36'h0, 4'h0);
        @(posedge clk_sys);
        #1;
        chk("a_q", mem[a], a_q);
        @(posedge clk_sys);
    endtask
    // ==========================================
    // Main sequence
    initial begin
        repeat (12) @(posedge clk_sys);
        arst_n <= 1'b1;
        @(posedge clk_sys);
        apb(1'b0, CRM_CFG_OFS, 32'h0);
        chk("cfg", 36'h50, rd);
        apb(1'b0, CRM_STAT_OFS, 32'h0);
        chk("stat", 36'h100, rd);
        apb(1'b1, 8'h08, 32'hffff_ffff);
        chk("pslverr", 36'h1, sl);
        // Registered output shows the cleared power-up value
        apb(1'b1, CRM_CFG_OFS, cfg(0, 1, 1, 0));
        chk("a_q reset", 36'h0, a_q);
        apb(1'b1, CRM_CFG_OFS, CRM_CFG_RST);
        wr_a(0, 36'h5_a5a5_a5a5, 4'hf);
        for (int i = 0; i < 24; i++) begin
            ad = $unsigned($random(seed)) % 128;
            v = 36'({$random(seed), $random(seed)});
            wr_a(ad, v, 4'hf);
            rd_a(ad);
        end
        wr_a(ad, ~mem[ad], 4'b0101);
        rd_a(ad);
        um.set_a(1'b0, 1'b1, 12'(ad), 36'h0, 4'h0);
        @(posedge clk_sys);
        in_clr <= 1'b1;
        um.idle();
        #1;
        chk("a_q in_clr", mem[0], a_q);
        @(posedge clk_sys);
        in_clr <= 1'b0;
        apb(1'b1, CRM_CFG_OFS, cfg(0, 1, 1, 0));
        um.set_a(1'b0, 1'b1, 12'(ad), 36'h0, 4'h0);
        repeat (2) @(posedge clk_sys);
        #1;
        chk("a_q reg", mem[ad], a_q);
        @(posedge clk_sys);
        out_clr <= 1'b1;
        um.idle();
        #1;
        chk("a_q out_clr", 36'h0, a_q);
        @(posedge clk_sys);
        out_clr <= 1'b0;
        for (int old = 1; old >= 0; old--) begin
            apb(1'b1, CRM_CFG_OFS, cfg(1, 0, old, 2));
            um.set_a(1'b1, 1'b0, 12'(ad), ~mem[ad], 4'hf);
            um.set_b(1'b0, 1'b1, 12'(ad << 2), 36'h0, 4'h0);
            @(posedge clk_sys);
            #1;
            chk("b_q clash", old ? 36'(mem[ad][8:0]) : 36'h1ff,
                36'(b_q[8:0]));
            @(posedge clk_sys);
            mem[ad] = ~mem[ad];
            um.idle();
            apb(1'b0, CRM_STAT_OFS, 32'h0);
            chk("clash", 36'h1, 36'(rd[0]));
            apb(1'b1, CRM_STAT_OFS, 32'h1);
            apb(1'b0, CRM_STAT_OFS, 32'h0);
            chk("clash w1c", 36'h0, 36'(rd[0]));
        end
        for (int l = 0; l < 4; l++) begin
            um.set_b(1'b0, 1'b1, 12'(ad << 2 | l), 36'h0, 4'h0);
            @(posedge clk_sys);
            #1;
            chk("b_q lane", 36'(mem[ad][9*l+:9]), 36'(b_q[8:0]));
            @(posedge clk_sys);
        end
        // Flow-through read address is taken on the falling edge
        apb(1'b1, CRM_CFG_OFS, cfg(1, 0, 0, 0) | 32'h20);
        um.set_b(1'b0, 1'b1, 12'(ad), 36'h0, 4'h0);
        @(negedge clk_sys);
        #1;
        chk("b_q flow", mem[ad], b_q);
        @(posedge clk_sys);
        results();
    end
    initial begin
        repeat (20000) @(posedge clk_sys);
        failures++;
        results();
    end
endmodule // testbench
`default_nettype wire
